/* File: core/itm_host_port.v */
`timescale 1ns/1ps
`default_nettype none
`include "itm_defs.vh"
module itm_host_port #(
	parameter REF_DIV = `ITM_REF_DIV
) (
	// Clock and reset
	input  wire        mclk,
	input  wire        nrst,
	// I/O port access, one cycle strobes
	input  wire [7:0]  io_addr,
	input  wire        io_wr,
	input  wire        io_rd,
	input  wire [7:0]  io_wdata,
	output reg  [7:0]  io_rdata,
	output reg         io_rvalid,
	// Counter pins
	input  wire [2:0]  gate,
	output reg  [2:0]  cnt_out
);
	// ****************************************
	// Shared decode
	// ****************************************
	// Three counters, each sixteen bits wide
	localparam NCNT = 3;

	wire              tick;
	wire              cmd_wr;
	wire              is_rb;
	wire [1:0]        acc_f;
	wire [1:0]        sel_f;
	// Per-counter results gathered flat so each has a single driver
	wire [8*NCNT-1:0] rd_bytes;
	wire [NCNT-1:0]   prog_v;
	wire [NCNT-1:0]   run_v;
	wire [NCNT-1:0]   zero_v;
	wire [NCNT-1:0]   next_cnt_out;

	// Command port is write only; reads there are answered with zero
	assign cmd_wr = io_wr && io_addr == `ITM_PORT_CMD;
	assign is_rb  = io_wdata[`ITM_SEL_HI:`ITM_SEL_LO] == `ITM_SEL_RB;
	assign acc_f  = io_wdata[`ITM_ACC_HI:`ITM_ACC_LO];
	assign sel_f  = io_wdata[`ITM_SEL_HI:`ITM_SEL_LO];

	// Shared reference tick; all three counters step on the same edge
	itm_ref_div #(
		.DIV  (REF_DIV)
	) u_div (
		.mclk (mclk),
		.nrst (nrst),
		.tick (tick)
	);

	// ****************************************
	// Per-counter logic
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < NCNT; g = g + 1) begin : gen_cnt
			wire        port_hit;
			wire        wr_hit;
			wire        rd_hit;
			wire        prog;
			wire        latch_req;
			wire        rb_cnt;
			wire        rb_sts;
			wire [15:0] dec_val;
			reg  [1:0]  acc;
			reg  [2:0]  mode;
			reg         bcd;
			reg  [15:0] count;
			reg  [15:0] preset;
			reg  [15:0] olatch;
			reg         olatch_full;
			reg         olatch_hi;
			reg  [7:0]  status;
			reg         status_full;
			reg         pending;
			reg         wr_hi;
			reg         rd_hi;
			reg         running;
			reg         gate_q;
			reg  [7:0]  lo_hold;
			reg  [7:0]  rd_sel;

			// Flat views for the shared read mux and pin logic
			assign rd_bytes[g*8 +: 8] = rd_sel;
			assign prog_v[g]          = prog;
			assign run_v[g]           = running;
			assign zero_v[g]          = count == 16'h0000;
			assign port_hit = io_addr == (`ITM_PORT_CNT0 + g);
			assign wr_hit   = io_wr && port_hit;
			assign rd_hit   = io_rd && port_hit;
			// Access field zero is a latch, never a reprogram
			assign prog     = cmd_wr && !is_rb && sel_f == g
				&& acc_f != `ITM_ACC_LATCH;
			// Latch from plain command or read-back selection
			assign latch_req = cmd_wr && ((!is_rb && sel_f == g
				&& acc_f == `ITM_ACC_LATCH) || rb_cnt);
			assign rb_cnt = is_rb && io_wdata[g+1]
				&& !io_wdata[`ITM_RB_CNT_N];
			assign rb_sts = cmd_wr && is_rb && io_wdata[g+1]
				&& !io_wdata[`ITM_RB_STS_N];

			itm_bcd_dec u_dec (
				.value  (count),
				.bcd    (bcd),
				.result (dec_val)
			);

			// ****************************************
			// Programming, loading and counting
			// ****************************************
			// A count write wins over a pending transfer in the same cycle,
			// so the transfer simply waits for the following tick
			always @(posedge mclk or negedge nrst) begin
				if (!nrst) begin
					acc     <= `ITM_ACC_BOTH;
					mode    <= 3'h0;
					bcd     <= 1'b0;
					count   <= 16'h0000;
					preset  <= 16'h0000;
					pending <= 1'b0;
					wr_hi   <= 1'b0;
					lo_hold <= 8'h00;
					running <= 1'b0;
					gate_q  <= 1'b0;
				end else begin
					gate_q <= gate[g];
					if (prog) begin
						acc     <= acc_f;
						mode    <= io_wdata[`ITM_MODE_HI:`ITM_MODE_LO];
						bcd     <= io_wdata[`ITM_BCD_BIT];
						wr_hi   <= 1'b0;
						running <= 1'b0;
					end else if (wr_hit) begin
						case (acc)
							`ITM_ACC_LOW: begin
								preset  <= {8'h00, io_wdata};
								pending <= 1'b1;
							end
							`ITM_ACC_HIGH: begin
								preset  <= {io_wdata, 8'h00};
								pending <= 1'b1;
							end
							`ITM_ACC_BOTH: begin
								// Low byte first, second write is high
								if (!wr_hi) begin
									lo_hold <= io_wdata;
									wr_hi   <= 1'b1;
								end else begin
									preset  <= {io_wdata, lo_hold};
									pending <= 1'b1;
									wr_hi   <= 1'b0;
								end
							end
							default: begin
								pending <= pending;
							end
						endcase
					end else if (tick && pending) begin
						// Transfer on a reference tick
						count   <= preset;
						pending <= 1'b0;
						running <= 1'b1;
					end else if (tick && running) begin
						// Modes 1 and 5 fire on a gate rise; others on level
						if (mode[1:0] == 2'h1 ? gate[g] && !gate_q
							: gate[g]) begin
							count <= dec_val;
						end
					end
				end
			end

			// ****************************************
			// Output latch and status latch
			// ****************************************
			// Reprogramming drops any unread capture; the host reloads anyway
			always @(posedge mclk or negedge nrst) begin
				if (!nrst) begin
					olatch      <= 16'h0000;
					olatch_full <= 1'b0;
					olatch_hi   <= 1'b0;
					status      <= 8'h00;
					status_full <= 1'b0;
					rd_hi       <= 1'b0;
				end else if (prog) begin
					olatch_full <= 1'b0;
					status_full <= 1'b0;
					olatch_hi   <= 1'b0;
					rd_hi       <= 1'b0;
				end else begin
					if (latch_req && !olatch_full) begin
						olatch      <= count;
						olatch_full <= 1'b1;
						olatch_hi   <= 1'b0;
					end
					// Status snapshot carries the pin level of this cycle
					if (rb_sts && !status_full) begin
						status      <= {cnt_out[g], pending, acc,
							mode, bcd};
						status_full <= 1'b1;
					end
					// Status goes out first, then the latched low and high bytes for two-byte access, or the one selected byte
					if (rd_hit) begin
						if (status_full) begin
							status_full <= 1'b0;
						end else if (olatch_full) begin
							if (acc == `ITM_ACC_BOTH && !olatch_hi) begin
								olatch_hi <= 1'b1;
							end else begin
								olatch_full <= 1'b0;
								olatch_hi   <= 1'b0;
							end
						end else if (acc == `ITM_ACC_BOTH) begin
							rd_hi <= !rd_hi;
						end
					end
				end
			end

			// ****************************************
			// Read byte select
			// ****************************************
			// Byte the next read of this port returns
			always @* begin
				if (status_full) begin
					rd_sel = status;
				end else if (olatch_full) begin
					if (acc == `ITM_ACC_HIGH || olatch_hi) begin
						rd_sel = olatch[15:8];
					end else begin
						rd_sel = olatch[7:0];
					end
				end else if (acc == `ITM_ACC_HIGH || rd_hi) begin
					rd_sel = count[15:8];
				end else begin
					rd_sel = count[7:0];
				end
			end
		end
	endgenerate

	// ****************************************
	// Counter output pins
	// ****************************************
	// Simple terminal-count indicator; mode waveforms are not modelled,
	// so the pin only tells a zero count from a running one
	assign next_cnt_out = ~prog_v & ((run_v & zero_v) | (~run_v & cnt_out));

	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cnt_out <= 3'h0;
		end else begin
			cnt_out <= next_cnt_out;
		end
	end

	// ****************************************
	// Read data return
	// ****************************************
	// Registered so the host sees steady data for one whole cycle after
	// the strobe; the command port and unmapped places still answer,
	// with zero, so the host never waits on a dead port
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			io_rdata  <= 8'h00;
			io_rvalid <= 1'b0;
		end else begin
			io_rvalid <= io_rd;
			case (io_addr)
				`ITM_PORT_CNT0: io_rdata <= io_rd ? rd_bytes[7:0] : 8'h00;
				`ITM_PORT_CNT1: io_rdata <= io_rd ? rd_bytes[15:8] : 8'h00;
				`ITM_PORT_CNT2: io_rdata <= io_rd ? rd_bytes[23:16] : 8'h00;
				default:        io_rdata <= 8'h00;
			endcase
		end
	end
endmodule
`default_nettype wire

/* File: include/itm_defs.vh */
`ifndef ITM_DEFS_VH
`define ITM_DEFS_VH
// Port addresses (low byte of the I/O address)
`define ITM_PORT_CNT0   8'h40
`define ITM_PORT_CNT1   8'h41
`define ITM_PORT_CNT2   8'h42
`define ITM_PORT_CMD    8'h43
// Command fields
`define ITM_SEL_HI      7
`define ITM_SEL_LO      6
`define ITM_ACC_HI      5
`define ITM_ACC_LO      4
`define ITM_MODE_HI     3
`define ITM_MODE_LO     1
`define ITM_BCD_BIT     0
`define ITM_RB_CNT_N    5
`define ITM_RB_STS_N    4
// Byte access codes and read-back select code
`define ITM_ACC_LATCH   2'h0
`define ITM_ACC_LOW     2'h1
`define ITM_ACC_HIGH    2'h2
`define ITM_ACC_BOTH    2'h3
`define ITM_SEL_RB      2'h3
// Reference divider
`define ITM_REF_DIV     12
// Wrap values for a zero count
`define ITM_BIN_MAX     16'hFFFF
`define ITM_BCD_MAX     16'h9999
`endif

/* File: core/itm_bcd_dec.v */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Sixteen-bit decrementer, binary or BCD
// ****************************************
module itm_bcd_dec (
	// Operand
	input  wire [15:0] value,
	input  wire        bcd,
	// Result
	output reg  [15:0] result
);
	integer i;
	reg     borrow;
	reg     [3:0] dig;

	// Binary subtracts one; BCD runs a digit-wise borrow chain, so zero wraps to 9999 naturally
	always @* begin
		result = 16'h0000;
		borrow = 1'b1;
		dig = 4'h0;
		if (!bcd) begin
			result = value - 16'h0001;
		end else begin
			for (i = 0; i < 4; i = i + 1) begin
				dig = value[i*4 +: 4];
				if (borrow && dig == 4'h0) begin
					result[i*4 +: 4] = 4'h9;
				end else begin
					result[i*4 +: 4] = dig - {3'h0, borrow};
					borrow = 1'b0;
				end
			end
		end
	end
endmodule
`default_nettype wire

/* File: core/itm_ref_div.v */
`timescale 1ns/1ps
`default_nettype none
`include "itm_defs.vh"
// ****************************************
// Reference tick: input clock divided down
// ****************************************
module itm_ref_div #(
	parameter DIV = `ITM_REF_DIV
) (
	// Clock and reset
	input  wire mclk,
	input  wire nrst,
	// Tick out
	output reg  tick
);
	reg [7:0] cnt;

	// One-cycle tick every DIV clocks
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cnt  <= 8'h00;
			tick <= 1'b0;
		end else if (cnt == DIV[7:0] - 8'h01) begin
			cnt  <= 8'h00;
			tick <= 1'b1;
		end else begin
			cnt  <= cnt + 8'h01;
			tick <= 1'b0;
		end
	end
endmodule
`default_nettype wire

/* File: testbench/itm_host_port_props.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Host port checker
// ****************************************
module itm_host_port_props (
	// Clock and reset
	input wire logic       mclk,
	input wire logic       nrst,
	// Host port
	input wire logic [7:0] io_addr,
	input wire logic       io_wr,
	input wire logic       io_rd,
	input wire logic [7:0] io_wdata,
	input wire logic [7:0] io_rdata,
	input wire logic       io_rvalid,
	// Counter pins
	input wire logic [2:0] gate,
	input wire logic [2:0] cnt_out
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	// Steps of a status fetch on counter zero
	sequence s_cmd0;
		io_wr && io_addr == 8'h43 && io_wdata[7:6] == 2'h0
			&& io_wdata[5:4] != 2'h0;
	endsequence
	sequence s_rb0;
		io_wr && io_addr == 8'h43
			&& (io_wdata == 8'hE2 || io_wdata == 8'hC2);
	endsequence
	sequence s_rd0;
		io_rd && io_addr == 8'h40;
	endsequence
	a_rvalid_follows: assert property (io_rd |=> io_rvalid)
		else $error("read strobe got no answer");
	a_rvalid_cause: assert property (io_rvalid |-> $past(io_rd))
		else $error("answer without read strobe");
	a_write_silent: assert property (io_wr && !io_rd |=> !io_rvalid)
		else $error("write produced an answer");
	a_cmd_unreadable: assert property (
		io_rd && io_addr == 8'h43 |=> io_rdata == 8'h00)
		else $error("command port read not zero");
	a_unmapped_zero: assert property (
		io_rd && (io_addr < 8'h40 || io_addr > 8'h43)
		|=> io_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_idle_zero: assert property (!io_rvalid |-> io_rdata == 8'h00)
		else $error("read data not zero while idle");
	a_status_fields: assert property (
		s_cmd0 ##2 s_rb0 ##2 s_rd0
		|=> (io_rdata & 8'h3F) == ($past(io_wdata, 5) & 8'h3F))
		else $error("status fields differ from command");
	a_status_pin: assert property (
		s_rb0 ##2 (s_rd0 and cnt_out[0] == $past(cnt_out[0], 2))
		|=> io_rdata[7] == $past(cnt_out[0]))
		else $error("status output bit wrong");
endmodule
bind itm_host_port itm_host_port_props chk (.mclk(mclk), .nrst(nrst),
	.io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
	.io_rdata(io_rdata), .io_rvalid(io_rvalid), .gate(gate), .cnt_out(cnt_out));
`default_nettype wire

/* File: testbench/itm_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Host processor on the I/O ports
// ****************************************
module itm_host_model (
	// Clock
	input wire logic       mclk,
	// Strobes out
	output var logic [7:0] io_addr,
	output var logic       io_wr,
	output var logic       io_rd,
	output var logic [7:0] io_wdata,
	// Answer in
	input wire logic [7:0] io_rdata,
	input wire logic       io_rvalid
);
	// Quiet bus at time zero
	initial begin
		io_addr = 8'h00;
		io_wr = 1'b0;
		io_rd = 1'b0;
		io_wdata = 8'h00;
	end
	// One-cycle write; released lines are inverted so no stale value lingers
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		#1;
		io_addr = a;
		io_wdata = d;
		io_wr = 1'b1;
		@(posedge mclk);
		#1;
		io_wr = 1'b0;
		io_wdata = ~d;
		io_addr = ~a;
	endtask
	// One-cycle read; data is taken once the answer has landed
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk);
		#1;
		io_addr = a;
		io_rd = 1'b1;
		@(posedge mclk);
		#1;
		io_rd = 1'b0;
		io_addr = ~a;
		d = io_rvalid ? io_rdata : 8'hXX;
	endtask
endmodule
`default_nettype wire

/* File: testbench/itm_host_port_test.sv */
`timescale 1ns/1ps
`default_nettype none
module itm_host_port_test;
	logic        mclk = 1'b0;
	logic        nrst = 1'b0;
	logic [2:0]  gate = 3'h0;
	wire  [7:0]  io_addr, io_wdata, io_rdata;
	wire         io_wr, io_rd, io_rvalid;
	wire  [2:0]  cnt_out;
	int          error_cnt = 0;
	int          samples_checked = 0;
	int          seed = 32'hdbc759c8;
	logic [7:0]  c, h, a, cmd, x;
	logic [15:0] v, w, r;
	// ****************************************
	// Clock, design and host
	// ****************************************
	always #5 mclk = ~mclk;
	// Short divider keeps load and count waits brief
	itm_host_port #(.REF_DIV(2)) uut (.mclk(mclk), .nrst(nrst),
		.io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
		.io_rdata(io_rdata), .io_rvalid(io_rvalid), .gate(gate),
		.cnt_out(cnt_out));
	itm_host_model host (.mclk(mclk), .io_addr(io_addr), .io_wr(io_wr),
		.io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
		.io_rvalid(io_rvalid));
	// ****************************************
	// Helpers
	// ****************************************
	task results;
		$display("checked %0d, errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task chk(input string n, input logic [15:0] e, input logic [15:0] s);
		samples_checked++;
		if (s !== e) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	// Status byte: pin level, load pending, then the command's low six bits
	function automatic logic [7:0] status_of(input logic lvl,
		input logic pend, input logic [7:0] cw);
		return {lvl, pend, cw[5:0]};
	endfunction
	task rd16(input logic [7:0] p, output logic [15:0] q);
		host.rd(p, q[7:0]);
		host.rd(p, q[15:8]);
	endtask
	task load(input logic [7:0] p, input logic [15:0] d);
		host.wr(p, d[7:0]);
		host.wr(p, d[15:8]);
		repeat (8) @(posedge mclk);
	endtask
	// Watchdog against a hung handshake
	initial begin
		#100000;
		error_cnt++;
		results;
	end
	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		repeat (16) @(posedge mclk);
		#1 nrst = 1'b1;
		// Latch held while a new count loads; stray latch ignored
		for (c = 0; c < 3; c++) begin
			v = $random(seed);
			w = $random(seed);
			host.wr(8'h43, {c[1:0], 6'h30});
			load(8'h40 + c, v);
			host.wr(8'h43, {c[1:0], 6'h00});
			load(8'h40 + c, w);
			host.wr(8'h43, {c[1:0], 6'h00});
			rd16(8'h40 + c, r);
			chk("latched", v, r);
			host.wr(8'h43, {c[1:0], 6'h00});
			rd16(8'h40 + c, r);
			chk("reloaded", w, r);
		end
		// Single-byte access: one read frees the latch
		v = $random(seed);
		host.wr(8'h43, 8'h50);
		host.wr(8'h41, v[7:0]);
		repeat (8) @(posedge mclk);
		host.wr(8'h43, 8'h40);
		host.rd(8'h41, h);
		chk("low only", v[7:0], h);
		host.wr(8'h43, 8'h60);
		host.wr(8'h41, v[15:8]);
		repeat (8) @(posedge mclk);
		host.wr(8'h43, 8'h40);
		host.rd(8'h41, h);
		chk("high only", v[15:8], h);
		host.wr(8'h41, ~v[15:8]);
		repeat (8) @(posedge mclk);
		host.wr(8'h43, 8'h40);
		host.rd(8'h41, h);
		chk("high again", {~v[15:8]}, h);
		// Read-back of two counters, second read-back ignored
		v = $random(seed) | 1;
		host.wr(8'h43, 8'h34);
		load(8'h40, v);
		host.wr(8'h43, 8'hB5);
		load(8'h42, 16'h4321);
		host.wr(8'h43, 8'hCA);
		load(8'h42, 16'h0011);
		host.wr(8'h43, 8'hC8);
		host.rd(8'h40, h);
		x = status_of(1'b0, 1'b0, 8'h34);
		chk("status 0", x, h);
		rd16(8'h40, r);
		chk("readback 0", v, r);
		host.rd(8'h42, h);
		x = status_of(1'b0, 1'b0, 8'hB5);
		chk("status 2", x, h);
		rd16(8'h42, r);
		chk("readback 2", 16'h4321, r);
		// Zero count wraps in binary and in BCD
		for (c = 0; c < 2; c++) begin
			host.wr(8'h43, 8'h70 | c);
			load(8'h41, 16'h0000);
			#1 gate = 3'h2;
			repeat (20) @(posedge mclk);
			#1 gate = 3'h0;
			host.wr(8'h43, 8'h40);
			rd16(8'h41, r);
			chk("wrap", c[0] ? 8'h99 : 8'hFF, r[15:8]);
		end
		// Every access, mode and format shows in status
		for (int i = 0; i < 36; i++) begin
			cmd = {2'h0, 2'(i % 3 + 1), 3'((i / 3) % 6), 1'(i / 18)};
			host.wr(8'h43, cmd);
			host.wr(8'h43, 8'hE2);
			host.rd(8'h40, h);
			x = status_of(1'b0, 1'b0, cmd);
			chk("fields", x, h);
		end
		// Zero count in mode 0 with gate low holds the pin high
		host.wr(8'h43, 8'h30);
		load(8'h40, 16'h0000);
		#1 chk("out level", 16'h0001, {15'h0000, cnt_out[0]});
		host.wr(8'h43, 8'hE2);
		host.rd(8'h40, h);
		x = status_of(1'b1, 1'b0, 8'h30);
		chk("status pin", x, h);
		// Control port and unmapped places read as zero
		a = $random(seed);
		if (a[7:2] == 6'h10)
			a = a ^ 8'h80;
		host.rd(8'h43, h);
		chk("cmd read", 8'h00, h);
		host.rd(a, h);
		chk("unmapped", 8'h00, h);
		results;
	end
endmodule
`default_nettype wire
